// file: rtl/esc_defines.svh
// Constants for the error syndrome classifier: encodings, offsets, resets.
`ifndef ESC_DEFINES_SVH
`define ESC_DEFINES_SVH
`define ESC_SYNC64_UC    2'h2
`define ESC_SYNC64_UER   2'h0
`define ESC_SYNC64_UEO   2'h3
`define ESC_A32_UC       2'h0
`define ESC_A32_UEU      2'h1
`define ESC_A32_UER      2'h3
`define ESC_A32_UEO      2'h2
`define ESC_A64_UC       3'h0
`define ESC_A64_UEU      3'h1
`define ESC_A64_UEO      3'h2
`define ESC_A64_UER      3'h3
`define ESC_A64_CE       3'h6
`define ESC_FSC_ASYNC    6'h11
`define ESC_FSC_SYNC     6'h10
`define ESC_OFF_CTRL     12'h000
`define ESC_OFF_RESULT   12'h004
`define ESC_OFF_SYND     12'h008
`define ESC_OFF_STATUS   12'h00c
`define ESC_OFF_MASK     12'h010
`define ESC_OFF_COUNT    12'h014
`define ESC_BIT_DONE     0
`define ESC_BIT_UC       1
`define ESC_BIT_REJ      2
`define ESC_CTRL_RESET   1'b1
`define ESC_MASK_RESET   3'h0
`endif

// file: rtl/esc_pkg.sv
// Types shared by the error syndrome classifier files.
package esc_pkg;
  typedef enum logic [1:0] {
    ESC_EXC_SYNC64,
    ESC_EXC_SERR64,
    ESC_EXC_SYNC32,
    ESC_EXC_SERR32
  } esc_exc_t;
  typedef enum logic [2:0] {
    ESC_ST_NONE,
    ESC_ST_UC,
    ESC_ST_UEU,
    ESC_ST_UER,
    ESC_ST_UEO,
    ESC_ST_CE,
    ESC_ST_UNCAT,
    ESC_ST_IMPDEF
  } esc_state_t;
  typedef struct packed {
    logic       silent_prop;
    logic       recoverable;
    logic       needs_repair;
    logic       synchronized;
    logic       corrected;
    esc_state_t elect;
  } esc_cond_t;
  typedef struct packed {
    logic       sync_valid;
    logic [1:0] sync_type;
    logic       async_valid;
    logic [2:0] async_type;
    logic       impdef_flag;
    logic [5:0] fsc;
  } esc_synd_t;
endpackage : esc_pkg

// file: rtl/esc_select.sv
// Combinational selection of the recorded error state.
`timescale 1ns/100ps
`default_nettype none
module esc_select
  import esc_pkg::*;
(
  // Exception kind and conditions
  input  wire esc_exc_t   exc,
  input  wire esc_cond_t  cond,
  // Selected state
  output var  esc_state_t state
);
  logic el_uc, el_ueu, el_uer, el_ueo, el_uncat, el_imp, a64s;
  always_comb begin
    a64s     = (exc == ESC_EXC_SERR64);
    el_uncat = (cond.elect == ESC_ST_UNCAT) && a64s;     // [RULE_04]
    el_imp   = (cond.elect == ESC_ST_IMPDEF) && a64s;    // [RULE_04]
    el_uc    = (cond.elect == ESC_ST_UC);                // [RULE_06]
    el_ueu   = (cond.elect == ESC_ST_UEU);
    el_uer   = (cond.elect == ESC_ST_UER);
    el_ueo   = (cond.elect == ESC_ST_UEO);
    state    = ESC_ST_NONE;
    // Stronger states are checked first; sync32 records none, uncat/impdef elections count only on system error 64, and a CE election needs corrected.
    if (exc == ESC_EXC_SYNC32) begin
      state = ESC_ST_NONE;                               // [RULE_09]
    end else if (el_uncat) begin
      state = ESC_ST_UNCAT;
    end else if (el_imp) begin
      state = ESC_ST_IMPDEF;                             // [RULE_09]
    end else if (cond.silent_prop || el_uc ||
                 (!cond.recoverable && !cond.synchronized) ||
                 (!cond.recoverable && exc == ESC_EXC_SYNC64)) begin
      state = ESC_ST_UC;                                 // [RULE_07] [RULE_08]
    end else if (!cond.recoverable || el_ueu) begin
      // An abort cannot carry unrecoverable, so it widens to uncontainable.
      state = (exc == ESC_EXC_SYNC64) ? ESC_ST_UC : ESC_ST_UEU; // [RULE_10]
    end else if (cond.needs_repair || el_uer) begin
      state = ESC_ST_UER;                                // [RULE_12]
    end else if (cond.corrected && a64s && !el_ueo) begin
      state = ESC_ST_CE;                                 // [RULE_14]
    end else begin
      state = ESC_ST_UEO;                                // [RULE_13]
    end
  end                                                    // [RULE_05]
endmodule : esc_select
`default_nettype wire

// file: rtl/esc_encode.sv
// Encodes the selected state into the syndrome fields of the exception.
`timescale 1ns/100ps
`default_nettype none
`include "esc_defines.svh"
module esc_encode
  import esc_pkg::*;
(
  // Inputs
  input  wire esc_exc_t   exc,
  input  wire esc_state_t state,
  // Syndrome
  output var  esc_synd_t  synd
);
  always_comb begin
    synd = '0;
    case (exc)
      ESC_EXC_SYNC64: begin
        synd.sync_valid = 1'b1;
        synd.fsc        = `ESC_FSC_SYNC;
        case (state)                                     // [RULE_01]
          ESC_ST_UER: synd.sync_type = `ESC_SYNC64_UER;
          ESC_ST_UEO: synd.sync_type = `ESC_SYNC64_UEO;
          default:    synd.sync_type = `ESC_SYNC64_UC;
        endcase
      end
      ESC_EXC_SERR32: begin
        synd.async_valid = 1'b1;
        synd.fsc         = `ESC_FSC_ASYNC;
        case (state)                                     // [RULE_02]
          ESC_ST_UEU: synd.async_type = {1'b0, `ESC_A32_UEU};
          ESC_ST_UER: synd.async_type = {1'b0, `ESC_A32_UER};
          ESC_ST_UEO: synd.async_type = {1'b0, `ESC_A32_UEO};
          default:    synd.async_type = {1'b0, `ESC_A32_UC};
        endcase
      end
      ESC_EXC_SERR64: begin
        case (state)
          ESC_ST_UNCAT: synd = '0;                       // [RULE_11]
          ESC_ST_IMPDEF: synd.impdef_flag = 1'b1;        // [RULE_11]
          default: begin
            synd.async_valid = 1'b1;
            synd.fsc         = `ESC_FSC_ASYNC;           // [RULE_11]
            case (state)                                 // [RULE_03]
              ESC_ST_UEU: synd.async_type = `ESC_A64_UEU;
              ESC_ST_UER: synd.async_type = `ESC_A64_UER;
              ESC_ST_UEO: synd.async_type = `ESC_A64_UEO;
              ESC_ST_CE:  synd.async_type = `ESC_A64_CE;
              default:    synd.async_type = `ESC_A64_UC;
            endcase
          end
        endcase
      end
      default: synd = '0;                                // [RULE_04]
    endcase
  end
endmodule : esc_encode
`default_nettype wire

// file: rtl/esc_classifier.sv
// Error syndrome classifier: latches the syndrome classified from the conditions at exception entry.
//
// How it works
// (RULE_01) Sync abort 64: two-bit code, three states.
// (RULE_02) System error 32: two-bit code, four states.
// (RULE_03) System error 64: three-bit codes, corrected 110.
// (RULE_04) Uncategorized/impdef only system error 64.
// (RULE_05) State chosen from kind, five conditions and election.
// (RULE_06) Elected state only where its conditions hold.
// (RULE_07) Uncontainable: propagated, unsynced unrecoverable, elected.
// (RULE_08) Unrecoverable sync abort 64 becomes uncontainable.
// (RULE_09) No uncontainable for sync32 or impdef/uncat.
// (RULE_10) Unrecoverable only for unpropagated system errors.
// (RULE_11) System error 64: flag, nonzero status code.
// (RULE_12) Recoverable when repair needed or elected.
// (RULE_13) Restartable when resumable without repair.
// (RULE_14) Corrected only on system error 64.
// (RULE_15) One cycle, all syndrome fields written together.
// (RULE_16) Conditions sampled with the exception request.
`timescale 1ns/100ps
`default_nettype none
`include "esc_defines.svh"
module esc_classifier
  import esc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Exception entry
  input  wire logic        exc_req,
  input  wire esc_exc_t    exc_kind,
  input  wire esc_cond_t   exc_cond,
  // Syndrome result
  output var  esc_synd_t   synd,
  output var  esc_state_t  rec_state,
  output var  logic        synd_valid,
  output var  logic        irq
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        enable;
    esc_synd_t   synd;
    esc_state_t  state;
    esc_exc_t    kind;
    logic        valid;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [15:0] count;
    logic        irq;
  } esc_regs_t;

  esc_regs_t  r, next_r;
  esc_state_t sel_state;
  esc_synd_t  sel_synd;
  logic       wr, rd, take;

  esc_select u_select (
    .exc   (exc_kind),
    .cond  (exc_cond),
    .state (sel_state)
  );

  esc_encode u_encode (
    .exc   (exc_kind),
    .state (sel_state),
    .synd  (sel_synd)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r  = r;
    wr      = psel && penable && pwrite;
    rd      = psel && !penable && !pwrite;
    take    = exc_req && r.enable;                       // [RULE_16]
    next_r.pready  = psel && !penable;
    next_r.pslverr = 1'b0;
    if (wr) begin
      case (paddr)
        `ESC_OFF_CTRL:   next_r.enable = pwdata[0];
        `ESC_OFF_STATUS: next_r.status = r.status & ~pwdata[2:0];
        `ESC_OFF_MASK:   next_r.mask   = pwdata[2:0];
        `ESC_OFF_COUNT:  next_r.count  = 16'h0000;
        `ESC_OFF_RESULT, `ESC_OFF_SYND: next_r.pslverr = 1'b0;
        default:         next_r.pslverr = 1'b0;
      endcase
    end
    if (rd) begin
      case (paddr)
        `ESC_OFF_CTRL:   next_r.prdata = {31'h0, r.enable};
        `ESC_OFF_RESULT: next_r.prdata = {24'h0, r.valid, r.kind,
                                          2'h0, r.state};
        `ESC_OFF_SYND:   next_r.prdata = {18'h0, r.synd};
        `ESC_OFF_STATUS: next_r.prdata = {29'h0, r.status};
        `ESC_OFF_MASK:   next_r.prdata = {29'h0, r.mask};
        `ESC_OFF_COUNT:  next_r.prdata = {16'h0, r.count};
        default: begin
          next_r.prdata  = 32'h0;
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && !penable && pwrite &&
        !(paddr inside {`ESC_OFF_CTRL, `ESC_OFF_RESULT, `ESC_OFF_SYND,
                        `ESC_OFF_STATUS, `ESC_OFF_MASK, `ESC_OFF_COUNT})) begin
      next_r.pslverr = 1'b1;
    end
    if (take) begin
      // Whole syndrome replaced at once so software never sees a mix.
      next_r.synd  = sel_synd;                           // [RULE_15]
      next_r.state = sel_state;
      next_r.kind  = exc_kind;
      next_r.valid = (exc_kind != ESC_EXC_SYNC32);       // [RULE_04]
      next_r.count = r.count + 16'h0001;
      // Event set wins over a same-cycle clear.
      next_r.status[`ESC_BIT_DONE] = 1'b1;
      if (sel_state == ESC_ST_UC) begin
        next_r.status[`ESC_BIT_UC] = 1'b1;
      end
    end
    if (exc_req && !r.enable) begin
      next_r.status[`ESC_BIT_REJ] = 1'b1;
    end
    next_r.irq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.enable <= `ESC_CTRL_RESET;
      r.mask   <= `ESC_MASK_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign prdata     = r.prdata;
  assign pready     = r.pready;
  assign pslverr    = r.pslverr;
  assign synd       = r.synd;
  assign rec_state  = r.state;
  assign synd_valid = r.valid;
  assign irq        = r.irq;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    exc_req && r.enable;
  endsequence

  AST_SYNC64_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    s_take ##0 exc_kind == ESC_EXC_SYNC64 |=> synd.sync_valid &&
      synd.sync_type != 2'h1) else $error("bad sync code"); // [RULE_01]
  AST_A32_NARROW: assert property (@(posedge pclk) disable iff (!presetn)
    s_take ##0 exc_kind == ESC_EXC_SERR32 |=> synd.async_type[2] == 1'b0)
    else $error("wide code for 32-bit system error"); // [RULE_02]
  AST_CE_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    s_take ##1 rec_state == ESC_ST_CE |-> synd.async_type == 3'h6 &&
      $past(exc_kind) == ESC_EXC_SERR64) else $error("corrected code"); // [RULE_03]
  AST_SYNC32_NONE: assert property (@(posedge pclk) disable iff (!presetn)
    s_take ##0 exc_kind == ESC_EXC_SYNC32 |=> !synd_valid && synd == '0)
    else $error("sync32 recorded syndrome"); // [RULE_04]
  AST_PROP_UC: assert property (@(posedge pclk) disable iff (!presetn)
    s_take ##0 exc_cond.silent_prop && exc_kind != ESC_EXC_SYNC32 &&
      exc_cond.elect inside {ESC_ST_NONE, ESC_ST_UC} |=> rec_state == ESC_ST_UC)
    else $error("propagated not uncontainable"); // [RULE_07]
  AST_SYNC64_UNREC: assert property (@(posedge pclk) disable iff (!presetn)
    s_take ##0 exc_kind == ESC_EXC_SYNC64 && !exc_cond.recoverable
      |=> rec_state == ESC_ST_UC) else $error("sync64 not uc"); // [RULE_08]
  AST_UEU_SERR: assert property (@(posedge pclk) disable iff (!presetn)
    s_take ##1 rec_state == ESC_ST_UEU |-> $past(exc_kind) inside
      {ESC_EXC_SERR32, ESC_EXC_SERR64}) else $error("ueu on abort"); // [RULE_10]
  AST_FLAG_VALID: assert property (@(posedge pclk) disable iff (!presetn)
    s_take ##1 synd.async_valid |-> !synd.impdef_flag && synd.fsc != 6'h0)
    else $error("async code without status"); // [RULE_11]
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(exc_req && r.enable) |=> $stable(synd)) else $error("syndrome moved"); // [RULE_15]
endmodule : esc_classifier
`default_nettype wire

// file: verif/esc_err_src.sv
// Model of the memory-system error source feeding exception entry.
`timescale 1ns/100ps
`default_nettype none
module esc_err_src
  import esc_pkg::*;
(
  // Clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // Commands from the bench
  input  wire logic      fire,
  input  wire esc_exc_t  kind_in,
  input  wire esc_cond_t cond_in,
  // Exception entry
  output var  logic      exc_req,
  output var  esc_exc_t  exc_kind,
  output var  esc_cond_t exc_cond
);
  ////////////////////////////////////////////////////////////////////////////
  // Between requests the kind and condition lines flip every cycle, so a classifier that
  // samples its conditions at any edge but the request edge is caught.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_req  <= 1'b0;
      exc_kind <= ESC_EXC_SYNC64;
      exc_cond <= '0;
    end else begin
      exc_req  <= fire;
      exc_kind <= fire ? kind_in : esc_exc_t'(~exc_kind);
      exc_cond <= fire ? cond_in : ~exc_cond;
    end
  end
endmodule // esc_err_src
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the error syndrome classifier.
`timescale 1ns/100ps
`default_nettype none
`include "esc_defines.svh"
module testbench
  import esc_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, fire = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, exc_req, synd_valid, irq, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  esc_exc_t    exc_kind, kind_in = ESC_EXC_SYNC64;
  esc_cond_t   exc_cond, cond_in = '0;
  esc_synd_t   synd;
  esc_state_t  rec_state;
  int          fails = 0, n_compared = 0;

  always #10 pclk = ~pclk;

  esc_classifier DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .exc_req(exc_req),
    .exc_kind(exc_kind), .exc_cond(exc_cond), .synd(synd),
    .rec_state(rec_state), .synd_valid(synd_valid), .irq(irq)
  );
  esc_err_src u_src (
    .pclk(pclk), .presetn(presetn), .fire(fire), .kind_in(kind_in),
    .cond_in(cond_in), .exc_req(exc_req), .exc_kind(exc_kind),
    .exc_cond(exc_cond)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_synd(esc_synd_t got, esc_synd_t exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Holds the request until pready is seen high at a rising edge, or gives up after 50 edges and counts a failure.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] code(esc_exc_t k, esc_state_t s);
    case ({k, s})
      {ESC_EXC_SYNC64, ESC_ST_UC}:  return 3'h2;
      {ESC_EXC_SYNC64, ESC_ST_UEO}: return 3'h3;
      {ESC_EXC_SERR32, ESC_ST_UEU}: return 3'h1;
      {ESC_EXC_SERR32, ESC_ST_UER}: return 3'h3;
      {ESC_EXC_SERR32, ESC_ST_UEO}: return 3'h2;
      {ESC_EXC_SERR64, ESC_ST_UEU}: return 3'h1;
      {ESC_EXC_SERR64, ESC_ST_UEO}: return 3'h2;
      {ESC_EXC_SERR64, ESC_ST_UER}: return 3'h3;
      {ESC_EXC_SERR64, ESC_ST_CE}:  return 3'h6;
      default: return 3'h0;
    endcase
  endfunction
  // Flags are {silent, recoverable, repair, synchronized, corrected}.
  task automatic exc(esc_exc_t k, logic [4:0] f, esc_state_t el,
                     esc_state_t es);
    esc_synd_t  e;
    logic [2:0] c;
    e = '0;
    @(posedge pclk);
    fire <= 1'b1;
    kind_in <= k;
    cond_in <= {f, el};
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
    #1;
    c = code(k, es);
    if (es == ESC_ST_IMPDEF) begin
      e.impdef_flag = 1'b1;
    end else if (k == ESC_EXC_SYNC64) begin
      e.sync_valid = 1'b1;
      e.sync_type = c[1:0];
      e.fsc = `ESC_FSC_SYNC;
    end else if (k != ESC_EXC_SYNC32 && es != ESC_ST_UNCAT) begin
      e.async_valid = 1'b1;
      e.async_type = c;
      e.fsc = `ESC_FSC_ASYNC;
    end
    chk(32'(rec_state), 32'(es));
    chk(32'(synd_valid), 32'(k != ESC_EXC_SYNC32));
    chk_synd(synd, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, `ESC_OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, `ESC_OFF_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask
  task automatic t_sync64();
    exc(ESC_EXC_SYNC64, 5'b00010, ESC_ST_NONE, ESC_ST_UC);
    exc(ESC_EXC_SYNC64, 5'b10000, ESC_ST_NONE, ESC_ST_UC);
    exc(ESC_EXC_SYNC64, 5'b01100, ESC_ST_NONE, ESC_ST_UER);
    exc(ESC_EXC_SYNC64, 5'b01001, ESC_ST_NONE, ESC_ST_UEO);
    exc(ESC_EXC_SYNC64, 5'b01000, ESC_ST_UEU, ESC_ST_UC);
  endtask
  task automatic t_serr();
    exc(ESC_EXC_SERR64, 5'b11001, ESC_ST_NONE, ESC_ST_UC);
    exc(ESC_EXC_SERR64, 5'b00000, ESC_ST_NONE, ESC_ST_UC);
    exc(ESC_EXC_SERR64, 5'b00010, ESC_ST_NONE, ESC_ST_UEU);
    exc(ESC_EXC_SERR64, 5'b01100, ESC_ST_NONE, ESC_ST_UER);
    exc(ESC_EXC_SERR64, 5'b01000, ESC_ST_NONE, ESC_ST_UEO);
    exc(ESC_EXC_SERR64, 5'b01001, ESC_ST_NONE, ESC_ST_CE);
    exc(ESC_EXC_SERR32, 5'b10000, ESC_ST_NONE, ESC_ST_UC);
    exc(ESC_EXC_SERR32, 5'b00010, ESC_ST_NONE, ESC_ST_UEU);
    exc(ESC_EXC_SERR32, 5'b01100, ESC_ST_NONE, ESC_ST_UER);
    exc(ESC_EXC_SERR32, 5'b01001, ESC_ST_NONE, ESC_ST_UEO);
  endtask
  task automatic t_elect();
    exc(ESC_EXC_SYNC32, 5'b10000, ESC_ST_UC, ESC_ST_NONE);
    exc(ESC_EXC_SERR64, 5'b10000, ESC_ST_UNCAT, ESC_ST_UNCAT);
    exc(ESC_EXC_SERR64, 5'b01000, ESC_ST_IMPDEF, ESC_ST_IMPDEF);
    exc(ESC_EXC_SERR32, 5'b01000, ESC_ST_UNCAT, ESC_ST_UEO);
    exc(ESC_EXC_SYNC64, 5'b01000, ESC_ST_IMPDEF, ESC_ST_UEO);
    exc(ESC_EXC_SERR64, 5'b01000, ESC_ST_UER, ESC_ST_UER);
    exc(ESC_EXC_SERR64, 5'b01001, ESC_ST_UEO, ESC_ST_UEO);
    exc(ESC_EXC_SERR64, 5'b01000, ESC_ST_UC, ESC_ST_UC);
    exc(ESC_EXC_SERR64, 5'b01000, ESC_ST_UEU, ESC_ST_UEU);
  endtask
  // The refused request reuses the last kind so unchanged outputs compare.
  task automatic t_irq();
    apb(1'b1, `ESC_OFF_STATUS, 32'h7);
    apb(1'b1, `ESC_OFF_COUNT, 32'h0);
    apb(1'b1, `ESC_OFF_MASK, 32'h2);
    exc(ESC_EXC_SERR64, 5'b10000, ESC_ST_NONE, ESC_ST_UC);
    apb(1'b0, `ESC_OFF_RESULT, 32'h0);
    chk(rd, 32'ha1);
    apb(1'b0, `ESC_OFF_STATUS, 32'h0);
    #1;
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `ESC_OFF_MASK, 32'h0);
    apb(1'b0, `ESC_OFF_MASK, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `ESC_OFF_MASK, 32'h2);
    apb(1'b1, `ESC_OFF_STATUS, 32'h2);
    apb(1'b0, `ESC_OFF_STATUS, 32'h0);
    #1;
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `ESC_OFF_CTRL, 32'h0);
    exc(ESC_EXC_SERR64, 5'b01000, ESC_ST_NONE, ESC_ST_UC);
    apb(1'b0, `ESC_OFF_STATUS, 32'h0);
    chk(rd, 32'h5);
    apb(1'b0, `ESC_OFF_COUNT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `ESC_OFF_CTRL, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sync64();
    t_serr();
    t_elect();
    t_irq();
    test_done();
  end
  // Whole run is about 140 cycles; this margin only catches a hang.
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    test_done();
  end
endmodule // testbench
`default_nettype wire
